// ---- verilog/gpx_map.svh ----
// Register offsets, reset values and bus constants of the expander
`ifndef GPX_MAP_SVH
`define GPX_MAP_SVH

`define GPX_SEL_IN0 3'h0
`define GPX_SEL_IN1 3'h1
`define GPX_SEL_OUT0 3'h2
`define GPX_SEL_OUT1 3'h3
`define GPX_SEL_INV0 3'h4
`define GPX_SEL_INV1 3'h5
`define GPX_SEL_DIR0 3'h6
`define GPX_SEL_DIR1 3'h7

`define GPX_RST_OUT 16'hffff
`define GPX_RST_INV 16'h0000
`define GPX_RST_DIR 16'hffff
`define GPX_RST_SEL 3'h0

`define GPX_ADDR_FIXED 4'h4
`define GPX_BITS_PER_BYTE 4'h8

`endif

// ---- verilog/gpx_pkg.sv ----
// Types shared by the expander modules
package gpx_pkg;

  typedef enum logic [2:0] {
    GPX_IDLE = 3'h0,
    GPX_ADDR = 3'h1,
    GPX_AACK = 3'h3,
    GPX_CMD = 3'h2,
    GPX_WACK = 3'h6,
    GPX_WDAT = 3'h7,
    GPX_TX = 3'h5,
    GPX_RACK = 3'h4
  } gpx_state_t;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] inv;
    logic [15:0] dir;
  } gpx_regs_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic [2:0] strap;
    logic [15:0] pins;
  } gpx_pins_t;

  typedef struct packed {
    logic [15:0] val;
    logic [15:0] oe_n;
  } gpx_drive_t;

  typedef struct packed {
    gpx_state_t state;
    gpx_regs_t regs;
    logic [2:0] sel;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic rw;
    logic acked;
    logic scl_q;
    logic sda_q;
    logic sda_oe_n;
    logic sda_out;
    gpx_drive_t drive;
  } gpx_core_t;

endpackage

// ---- verilog/gpx_sync.sv ----
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module gpx_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s2;
    logic [W-1:0] s1;
  } gpx_sync_st_t;

  gpx_sync_st_t st;
  gpx_sync_st_t next_st;

  always_comb begin
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Idle bus level, so no false scl or sda edge follows reset
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;
endmodule // gpx_sync

// ---- verilog/gpx_pin_bank.sv ----
// Per-pin sensed level and driver values
`timescale 1ns/1ps
module gpx_pin_bank #(
  parameter int W = 16
) (
  // Register contents
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] inv,
  // Pin side
  input wire logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] drv_val,
  output logic [W-1:0] drv_oe_n
);
  for (genvar i = 0; i < W; i++) begin : g_pin
    // Pin levels read back whatever the direction
    assign level[i] = pins[i] ^ inv[i];
    // Latch reaches the pin only when it is an output
    assign drv_oe_n[i] = dir[i];
    assign drv_val[i] = latch[i];
  end
endmodule // gpx_pin_bank

// ---- verilog/gpx_expander.sv ----
// Sixteen-bit I/O expander: serial slave, registers and pin logic
`timescale 1ns/1ps
`include "gpx_map.svh"

// Functional notes
// - Input registers always show the current pin levels, any direction.
// - Writes to the input registers are ignored.
// - Input registers have no reset value; they follow the pins.
// - Output pins drive the level held in their latch bit.
// - Latch bits of input pins do not touch the pins.
// - Latch reads return the stored bits, not the pin levels.
// - Output latches reset to all ones.
// - An invert bit of one inverts the sensed pin level.
// - An invert bit of zero keeps the sensed level as is.
// - Invert registers reset to all zeros.
// - A direction bit of one makes the pin a high-impedance input.
// - A direction bit of zero makes the pin an output.
// - Direction registers reset to all ones, all pins inputs.
// - Command byte is stored; its low three bits select one register.
// - Reads keep using the selected register until a new command.
// - Each further byte alternates to the other register of the pair.
module gpx_expander (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial bus, address straps and port pins, all asynchronous
  input wire gpx_pkg::gpx_pins_t pins_in,
  // Serial data open-drain driver
  output logic sda_out,
  output logic sda_oe_n,
  // Port pin drivers
  output gpx_pkg::gpx_drive_t pin_drive
);
  import gpx_pkg::*;

  gpx_core_t st;
  gpx_core_t next_st;
  gpx_pins_t pins_s;
  logic [15:0] level;
  logic [15:0] drv_val;
  logic [15:0] drv_oe_n;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic byte_done;
  logic addr_hit;
  logic wr_stb;

  // Every external level is synchronised before use
  gpx_sync #(
    .W($bits(gpx_pins_t))
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pins_in),
    .q(pins_s)
  );

  gpx_pin_bank #(
    .W(16)
  ) u_bank (
    .latch(st.regs.out),
    .dir(st.regs.dir),
    .inv(st.regs.inv),
    .pins(pins_s.pins),
    .level(level),
    .drv_val(drv_val),
    .drv_oe_n(drv_oe_n)
  );

  // Byte returned for the selected register; bit n is pin n of the port
  function automatic logic [7:0] read_mux(input logic [2:0] sel,
                                          input logic [15:0] lvl,
                                          input gpx_regs_t r);
    logic [15:0] word;
    word = lvl;
    unique case (sel[2:1])
      2'h0: word = lvl;
      2'h1: word = r.out;
      2'h2: word = r.inv;
      2'h3: word = r.dir;
    endcase
    return sel[0] ? word[15:8] : word[7:0];
  endfunction

  // Edge and condition detection on the synchronised bus lines
  assign scl_rise = pins_s.scl && !st.scl_q;
  assign scl_fall = !pins_s.scl && st.scl_q;
  assign bus_start = pins_s.scl && st.scl_q && st.sda_q && !pins_s.sda;
  assign bus_stop = pins_s.scl && st.scl_q && !st.sda_q && pins_s.sda;
  assign byte_done = scl_fall && (st.cnt == `GPX_BITS_PER_BYTE);
  assign addr_hit = (st.shift[7:1] == {`GPX_ADDR_FIXED, pins_s.strap});
  assign wr_stb = (st.state == GPX_WDAT) && byte_done;

  always_comb begin
    next_st = st;
    next_st.scl_q = pins_s.scl;
    next_st.sda_q = pins_s.sda;
    next_st.drive.val = drv_val;
    next_st.drive.oe_n = drv_oe_n;
    next_st.sda_out = 1'b0;
    if (bus_stop) begin
      next_st.state = GPX_IDLE;
      next_st.sda_oe_n = 1'b1;
    end else if (bus_start) begin
      // A repeated start restarts the address phase; selection is kept
      next_st.state = GPX_ADDR;
      next_st.cnt = 4'h0;
      next_st.sda_oe_n = 1'b1;
    end else begin
      unique case (st.state)
        GPX_IDLE: begin
          next_st.sda_oe_n = 1'b1;
        end
        GPX_ADDR, GPX_CMD, GPX_WDAT: begin
          if (scl_rise && st.cnt != `GPX_BITS_PER_BYTE) begin
            next_st.shift = {st.shift[6:0], pins_s.sda};
            next_st.cnt = st.cnt + 4'h1;
          end else if (byte_done) begin
            next_st.cnt = 4'h0;
            next_st.sda_oe_n = 1'b0;
            if (st.state == GPX_ADDR) begin
              next_st.rw = st.shift[0];
              if (addr_hit) begin
                next_st.state = GPX_AACK;
              end else begin
                // Not for us: stay off the bus until the next start
                next_st.state = GPX_IDLE;
                next_st.sda_oe_n = 1'b1;
              end
            end else if (st.state == GPX_CMD) begin
              next_st.sel = st.shift[2:0];
              next_st.state = GPX_WACK;
            end else begin
              unique case (st.sel[2:1])
                2'h0: begin
                  // Input registers are read-only; byte is dropped
                  next_st.regs = st.regs;
                end
                2'h1: begin
                  if (st.sel[0]) begin
                    next_st.regs.out[15:8] = st.shift;
                  end else begin
                    next_st.regs.out[7:0] = st.shift;
                  end
                end
                2'h2: begin
                  if (st.sel[0]) begin
                    next_st.regs.inv[15:8] = st.shift;
                  end else begin
                    next_st.regs.inv[7:0] = st.shift;
                  end
                end
                2'h3: begin
                  if (st.sel[0]) begin
                    next_st.regs.dir[15:8] = st.shift;
                  end else begin
                    next_st.regs.dir[7:0] = st.shift;
                  end
                end
              endcase
              // Further write bytes go to the other register of the pair
              next_st.sel = {st.sel[2:1], ~st.sel[0]};
              next_st.state = GPX_WACK;
            end
          end
        end
        GPX_AACK: begin
          if (scl_fall) begin
            if (st.rw) begin
              // Snapshot taken at the ack clock, as the pins stand now
              next_st.shift = read_mux(st.sel, level, st.regs);
              next_st.sda_oe_n = read_mux(st.sel, level, st.regs) >> 7 != 8'h0;
              next_st.cnt = 4'h0;
              next_st.state = GPX_TX;
            end else begin
              next_st.sda_oe_n = 1'b1;
              next_st.state = GPX_CMD;
            end
          end
        end
        GPX_WACK: begin
          if (scl_fall) begin
            next_st.sda_oe_n = 1'b1;
            next_st.state = GPX_WDAT;
          end
        end
        GPX_TX: begin
          if (scl_fall) begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == `GPX_BITS_PER_BYTE - 4'h1) begin
              next_st.sda_oe_n = 1'b1;
              next_st.state = GPX_RACK;
            end else begin
              next_st.shift = {st.shift[6:0], 1'b0};
              next_st.sda_oe_n = st.shift[6];
            end
          end
        end
        GPX_RACK: begin
          if (scl_rise) begin
            next_st.acked = !pins_s.sda;
          end else if (scl_fall) begin
            if (st.acked) begin
              next_st.sel = {st.sel[2:1], ~st.sel[0]};
              next_st.shift = read_mux({st.sel[2:1], ~st.sel[0]}, level,
                                       st.regs);
              next_st.sda_oe_n = read_mux({st.sel[2:1], ~st.sel[0]}, level,
                                          st.regs) >> 7 != 8'h0;
              next_st.cnt = 4'h0;
              next_st.state = GPX_TX;
            end else begin
              // Master refused the byte: release and wait for stop
              next_st.state = GPX_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st.state <= GPX_IDLE;
      st.regs.out <= `GPX_RST_OUT;
      st.regs.inv <= `GPX_RST_INV;
      st.regs.dir <= `GPX_RST_DIR;
      st.sel <= `GPX_RST_SEL;
      st.shift <= 8'h00;
      st.cnt <= 4'h0;
      st.rw <= 1'b0;
      st.acked <= 1'b0;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.sda_oe_n <= 1'b1;
      st.sda_out <= 1'b0;
      st.drive.val <= `GPX_RST_OUT;
      st.drive.oe_n <= `GPX_RST_DIR;
    end else begin
      st <= next_st;
    end
  end

  assign sda_out = st.sda_out;
  assign sda_oe_n = st.sda_oe_n;
  assign pin_drive = st.drive;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_INPUT_READ: assert property (
    st.state == GPX_AACK && scl_fall && st.rw && st.sel == `GPX_SEL_IN0
    |=> st.shift == $past(level[7:0]) && st.state == GPX_TX)
    else $error("Input byte does not match sensed level");

  AST_INPUT_RO: assert property (
    wr_stb && st.sel[2:1] == 2'h0 |=> $stable(st.regs))
    else $error("Write to input register changed state");

  AST_PIN_DRIVE: assert property (
    ##1 pin_drive.val == $past(st.regs.out) &&
    pin_drive.oe_n == $past(st.regs.dir))
    else $error("Pin drivers do not follow latch and direction");

  AST_RESET_VAL: assert property (disable iff (1'b0)
    !rst_n |=> st.regs.out == `GPX_RST_OUT && st.regs.inv == `GPX_RST_INV
    && st.regs.dir == `GPX_RST_DIR && pin_drive.oe_n == `GPX_RST_DIR)
    else $error("Wrong register values after reset");

  AST_LATCH_READ: assert property (
    st.state == GPX_AACK && scl_fall && st.rw && st.sel == `GPX_SEL_OUT1
    |=> st.shift == $past(st.regs.out[15:8]))
    else $error("Latch read does not return stored bits");

  AST_PAIR_STEP: assert property (
    st.state == GPX_RACK && scl_fall && st.acked
    |=> st.sel == {$past(st.sel[2:1]), ~$past(st.sel[0])} ##0
    st.state == GPX_TX)
    else $error("Read did not move to the pair register");

  AST_SEL_HOLD: assert property (
    st.state inside {GPX_IDLE, GPX_ADDR, GPX_AACK, GPX_TX} |=> $stable(st.sel))
    else $error("Selection changed without a command or read step");

  AST_CMD_STORE: assert property (
    st.state == GPX_CMD && byte_done
    |=> st.sel == $past(st.shift[2:0]) && st.state == GPX_WACK
    && !sda_oe_n)
    else $error("Command byte not stored or not acknowledged");

  AST_INVERT: assert property (
    level == (pins_s.pins ^ st.regs.inv))
    else $error("Sensed level ignores invert bits");

  // Register stores, address acknowledge and read sequencing
  AST_LATCH_STORE: assert property (
    wr_stb && st.sel == `GPX_SEL_OUT0
    |=> st.regs.out[7:0] == $past(st.shift))
    else $error("Latch byte not stored on write");

  AST_INV_STORE: assert property (
    wr_stb && st.sel == `GPX_SEL_INV0
    |=> st.regs.inv[7:0] == $past(st.shift))
    else $error("Invert byte not stored on write");

  AST_DIR_STORE: assert property (
    wr_stb && st.sel == `GPX_SEL_DIR1
    |=> st.regs.dir[15:8] == $past(st.shift))
    else $error("Direction byte not stored on write");

  AST_PORT1_READ: assert property (
    st.state == GPX_AACK && scl_fall && st.rw && st.sel == `GPX_SEL_IN1
    |=> st.shift == $past(level[15:8]))
    else $error("Port 1 input byte does not match sensed level");

  AST_READ_MSB: assert property (
    st.state == GPX_AACK && scl_fall && st.rw
    |=> sda_oe_n == st.shift[7])
    else $error("Read byte does not start with its top bit");

  AST_NACK_RELEASE: assert property (
    st.state == GPX_RACK && scl_fall && !st.acked
    |=> st.state == GPX_IDLE && sda_oe_n)
    else $error("Data line not released after a refused byte");

  AST_ADDR_ACK: assert property (
    st.state == GPX_ADDR && byte_done && addr_hit
    |=> st.state == GPX_AACK && !sda_oe_n)
    else $error("Own address not acknowledged");

  COV_WRITE_DIR: cover property (wr_stb && st.sel[2:1] == 2'h3);
  COV_READ_PAIR: cover property (
    st.state == GPX_RACK && scl_fall && st.acked);
  COV_NACK_END: cover property (
    st.state == GPX_RACK && scl_fall && !st.acked);
  COV_ADDR_MISS: cover property (
    st.state == GPX_ADDR && byte_done && !addr_hit);
  COV_INPUT_WRITE: cover property (wr_stb && st.sel[2:1] == 2'h0);
endmodule // gpx_expander

// ---- bench/gpx_i2c_master.sv ----
// Serial bus master model for the expander's serial port
`timescale 1ns/1ps
module gpx_i2c_master (
  // Clock
  input wire logic clk,
  // Data line level on the wire
  input wire logic sda_wire,
  // Driven lines, sda_low pulls the data line down
  output logic scl,
  output logic sda_low
);
  // Extra high time per bit, for slow-master runs
  int slow = 0;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Data moves only while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(4 + slow);
    s = sda_wire;
    scl = 1'b0;
    tick(2);
  endtask

  task automatic start_cond();
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask

  // Clock is left standing high between frames
  task automatic stop_cond();
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(8);
  endtask

  task automatic send(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack_n);
  endtask

  // Last byte is refused so the slave lets go of the line
  task automatic recv(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask
endmodule // gpx_i2c_master

// ---- bench/gpx_expander_tb_top.sv ----
// Self-checking bench for the expander registers and pins
`timescale 1ns/1ps
`include "gpx_map.svh"
module gpx_expander_tb_top;
  import gpx_pkg::*;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk;
  logic rst_n;
  logic scl;
  logic sda_low;
  logic sda_wire;
  logic sda_out;
  logic sda_oe_n;
  logic [15:0] ext_pins;
  logic [15:0] pin_now;
  gpx_pins_t pins_in;
  gpx_drive_t pin_drive;
  int error_cnt = 0;
  int comparisons = 0;

  // Pull-up on the data line, either party may pull it low
  assign sda_wire = ~sda_low & (sda_oe_n | sda_out);
  // Output pins show the driver, input pins the outside level
  assign pin_now = (pin_drive.oe_n & ext_pins) |
                   (~pin_drive.oe_n & pin_drive.val);
  assign pins_in = {scl, sda_wire, STRAP, pin_now};

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  gpx_expander dut (
    .clk(clk),
    .rst_n(rst_n),
    .pins_in(pins_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .pin_drive(pin_drive)
  );

  gpx_i2c_master mst (
    .clk(clk),
    .sda_wire(sda_wire),
    .scl(scl),
    .sda_low(sda_low)
  );

  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Command byte, then up to two data bytes into the register pair
  task automatic wr(input logic [7:0] cmd, input int n,
                    input logic [15:0] d);
    logic [3:0] a;
    a = 4'h0;
    mst.start_cond();
    mst.send({`GPX_ADDR_FIXED, STRAP, 1'b0}, a[0]);
    mst.send(cmd, a[1]);
    if (n > 0) mst.send(d[7:0], a[2]);
    if (n > 1) mst.send(d[15:8], a[3]);
    mst.stop_cond();
    check({12'h000, a}, 16'h0000);
  endtask

  // Optional fresh command, then one or two read bytes
  task automatic chk_rd(input logic [7:0] cmd, input logic set,
                        input int n, input logic [15:0] exp);
    logic a;
    logic [15:0] q;
    q = 16'h0000;
    if (set) wr(cmd, 0, 16'h0000);
    mst.start_cond();
    mst.send({`GPX_ADDR_FIXED, STRAP, 1'b1}, a);
    check({15'h0000, a}, 16'h0000);
    mst.recv(n == 1, q[7:0]);
    if (n > 1) mst.recv(1'b1, q[15:8]);
    mst.stop_cond();
    check(q, exp);
  endtask

  // Four cycles after release let the synchronisers fill
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic reset_checks();
    check(pin_drive.oe_n, 16'hffff);
    check(pin_drive.val, 16'hffff);
    chk_rd(8'h02, 1'b1, 2, 16'hffff);
    chk_rd(8'h04, 1'b1, 2, 16'h0000);
    chk_rd(8'h06, 1'b1, 2, 16'hffff);
  endtask

  initial begin
    rst_n = 1'b0;
    ext_pins = 16'ha5c3;
    do_reset();
    reset_checks();
    chk_rd(8'h00, 1'b1, 2, 16'ha5c3);
    chk_rd(8'h01, 1'b1, 2, 16'hc3a5);
    wr(8'h00, 2, 16'h1234);
    chk_rd(8'h00, 1'b1, 2, 16'ha5c3);
    wr(8'h02, 2, 16'h3c5a);
    check(pin_drive.oe_n, 16'hffff);
    check(pin_drive.val, 16'h3c5a);
    wr(8'h06, 2, 16'h0ff0);
    check(pin_drive.oe_n, 16'h0ff0);
    chk_rd(8'h00, 1'b1, 2, 16'h35ca);
    chk_rd(8'h02, 1'b1, 2, 16'h3c5a);
    wr(8'h04, 2, 16'h00ff);
    chk_rd(8'h00, 1'b1, 2, 16'h3535);
    chk_rd(8'h04, 1'b1, 2, 16'h00ff);
    chk_rd(8'hfb, 1'b1, 1, 16'h003c);
    chk_rd(8'h00, 1'b0, 1, 16'h003c);
    mst.slow = 6;
    ext_pins = 16'h5a00;
    chk_rd(8'h00, 1'b1, 2, 16'h3af5);
    mst.slow = 0;
    wr(8'h06, 1, 16'h00ff);
    check(pin_drive.oe_n, 16'h0fff);
    do_reset();
    reset_checks();
    end_of_test();
  end

  // Whole sequence needs well under a millisecond
  initial begin
    #3000000;
    error_cnt++;
    end_of_test();
  end
endmodule // gpx_expander_tb_top
